// ===== core/serial_wiper_latch_loader.v
`timescale 1ns/10ps
`include "wiper_loader_consts.vh"

// Summary of operation
// RQ1: Single-channel word is 8 bits, most significant bit first.
// RQ2: Dual-channel word is 9 bits: address bit then eight data bits MSB first.
// RQ3: Dual word holds the address in B8 and the wiper code in B7..B0.
// RQ4: Address 0 picks the first wiper latch, 1 picks the second.
// RQ5: With select low, each rising serial clock shifts one input bit in. The code does not shift while preset is low.
// RQ6: Chain output carries the bit that entered eight shifts earlier.
// RQ7: Select low and clock low leaves the register alone and enables output.
// RQ8: Single-channel variant loads the 8-bit register when select rises.
// RQ9: Dual-channel variant keeps only the last nine bits shifted in.
// RQ10: Select rising loads only the addressed latch with eight data bits.
// RQ11: Master sends one 9-bit word per channel to update both.
// RQ12: Preset low forces all latches to midscale and clears chain output.
// RQ13: Preset rising with select high latches 0x80 into all latches.
// RQ14: Power-down opens A terminals, ties wiper to B, floats chain output.
// RQ15: Power-down keeps latch contents for restoration afterwards.
// RQ16: Power-on presets every latch to midscale.
// RQ17: Each code drives exactly one of 256 tap switches.
// RQ18: Two chained single devices take 16 bits with select held low.
// RQ19: Master should slow the serial clock in a daisy chain.
// RQ20: Channels update individually in any order; each word hits one latch.
// RQ21: Preset held low outranks a select rising edge.
module serial_wiper_latch_loader #(
  parameter DUAL = 1,
  parameter CODE_W = `WL_CODE_W,
  parameter TAPS = `WL_TAPS
) (
  // Clock and reset
  input wire REF_CLK_I,
  input wire SRST_I,
  // Serial link pins
  input wire SCLK_I,
  input wire CS_N_I,
  input wire SERIAL_IN_I,
  // Preset and power-down pins, both active low
  input wire PRESET_MID_N_I,
  input wire POWER_DOWN_N_I,
  // Open-drain daisy-chain pin
  output reg CHAIN_OUT_O,
  output reg CHAIN_OUT_OE_N_O,
  // Latch codes and one-hot tap switches
  output reg [CODE_W-1:0] WIPER0_CODE_O,
  output reg [CODE_W-1:0] WIPER1_CODE_O,
  output reg [TAPS-1:0] WIPER0_TAP_O,
  output reg [TAPS-1:0] WIPER1_TAP_O,
  // Terminal switches for power-down
  output reg A_TERM_OPEN_O,
  output reg WIPER_TO_B_O
);
  // Serial register is long enough for the dual-channel word
  localparam SR_W = `WL_DUAL_LEN;

  // Pin levels after the two-flop synchronisers
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;
  wire pr_n_s;
  wire pd_n_s;

  // Edge history of the serial clock and the select
  reg sclk_q;
  reg cs_n_q;
  wire sclk_rise;
  wire cs_rise;

  // Serial shift register and daisy-chain latch
  reg [SR_W-1:0] shift_q;
  reg [SR_W-1:0] shift_d;
  reg chain_q;
  reg chain_d;
  reg chain_oe_n_d;

  // Preset, power-down and load control
  wire preset_act;
  wire power_down_act;
  wire shift_en;
  wire addr_bit;
  wire load0;
  wire load1;

  // Latch contents and tap decodes
  wire [CODE_W-1:0] code0;
  wire [CODE_W-1:0] code1;
  wire [TAPS-1:0] tap0;
  wire [TAPS-1:0] tap1;

  // Serial clock pin, idle low
  input_sync #(
    .RESET_VAL(1'h0)
  ) u_sync_sclk (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .async_i(SCLK_I),
    .sync_o(sclk_s)
  );

  // Select pin, idle high
  input_sync #(
    .RESET_VAL(1'h1)
  ) u_sync_cs (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .async_i(CS_N_I),
    .sync_o(cs_n_s)
  );

  // Serial data pin
  input_sync #(
    .RESET_VAL(1'h0)
  ) u_sync_sdi (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .async_i(SERIAL_IN_I),
    .sync_o(sdi_s)
  );

  // Preset pin, idle high
  input_sync #(
    .RESET_VAL(1'h1)
  ) u_sync_pr (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .async_i(PRESET_MID_N_I),
    .sync_o(pr_n_s)
  );

  // Power-down pin, idle high
  input_sync #(
    .RESET_VAL(1'h1)
  ) u_sync_pd (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .async_i(POWER_DOWN_N_I),
    .sync_o(pd_n_s)
  );

  // Previous serial clock level; resets to the idle low level
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sclk_q <= 1'h0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // Previous select level; resets to the idle high level, so no false load
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      cs_n_q <= 1'h1;
    end else begin
      cs_n_q <= cs_n_s;
    end
  end

  // One-cycle pulses on the rising pin edges
  assign sclk_rise = sclk_s & ~sclk_q;
  assign cs_rise = cs_n_s & ~cs_n_q;
  // A shift happens only inside a frame; a low clock leaves the register alone
  assign shift_en = ~cs_n_s & sclk_rise; // [RQ5] [RQ7]
  // Preset level covers its own rising edge, since the latches then hold 0x80
  assign preset_act = ~pr_n_s;
  // Power-down level; the latches keep their contents meanwhile
  assign power_down_act = ~pd_n_s;

  // Next shift register and chain latch; preset clears the latch and stalls shifting
  always @* begin
    shift_d = shift_q;
    chain_d = chain_q;
    if (preset_act) begin
      chain_d = 1'h0; // [RQ12]
    end else if (shift_en) begin
      shift_d = {shift_q[SR_W-2:0], sdi_s}; // [RQ1] [RQ2] [RQ5] [RQ9]
      chain_d = shift_q[`WL_CHAIN_DEPTH-1]; // [RQ6]
    end
  end

  // Shift register, MSB first; in single mode only the low eight bits matter
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      shift_q <= {SR_W{1'h0}};
    end else begin
      shift_q <= shift_d;
    end
  end

  // Daisy-chain latch holds its bit between shifts
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      chain_q <= 1'h0;
    end else begin
      chain_q <= chain_d;
    end
  end

  // Channel address sits in B8 of the dual word; single mode addresses latch 0 only
  assign addr_bit = (DUAL != 0) ? shift_q[`WL_ADDR_POS] : 1'h0; // [RQ3]
  // Select rising loads exactly the addressed latch; preset blocks the load
  assign load0 = cs_rise & ~preset_act & ~addr_bit; // [RQ4] [RQ8] [RQ10] [RQ21]
  // Latch 1 loads only in the dual-channel variant
  assign load1 = cs_rise & ~preset_act & addr_bit & (DUAL != 0); // [RQ4] [RQ20]

  // Wiper latches, preset to midscale at reset and while preset is low
  wiper_latch #(.CODE_W(CODE_W), .TAPS(TAPS)) u_latch0 (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I), // [RQ16]
    .preset_i(preset_act), // [RQ12] [RQ13]
    .load_i(load0),
    .code_i(shift_q[CODE_W-1:0]),
    .code_o(code0),
    .tap_o(tap0)
  );

  // Second latch shares the shift register but has its own load strobe
  wiper_latch #(.CODE_W(CODE_W), .TAPS(TAPS)) u_latch1 (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .preset_i(preset_act),
    .load_i(load1),
    .code_i(shift_q[CODE_W-1:0]),
    .code_o(code1),
    .tap_o(tap1)
  );

  // Open drain: pull low only for a zero inside a frame, float high in power-down
  always @* begin
    chain_oe_n_d = 1'h1; // Released by default [RQ14]
    if (~power_down_act && ~cs_n_s && ~chain_q) begin
      chain_oe_n_d = 1'h0; // [RQ7]
    end
  end

  // Data value of the open-drain pin is always a zero
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      CHAIN_OUT_O <= 1'h0;
    end else begin
      CHAIN_OUT_O <= 1'h0;
    end
  end

  // Chain pin enable, released at reset
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      CHAIN_OUT_OE_N_O <= 1'h1;
    end else begin
      CHAIN_OUT_OE_N_O <= chain_oe_n_d; // [RQ7] [RQ14]
    end
  end

  // Latch 0 code; power-down only gates the pins and leaves it intact
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      WIPER0_CODE_O <= `WL_MIDSCALE;
    end else begin
      WIPER0_CODE_O <= code0; // [RQ15]
    end
  end

  // Latch 1 code
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      WIPER1_CODE_O <= `WL_MIDSCALE;
    end else begin
      WIPER1_CODE_O <= code1; // [RQ15]
    end
  end

  // Latch 0 tap switches, midscale tap at reset
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      WIPER0_TAP_O <= {{(TAPS-1){1'h0}}, 1'h1} << `WL_MIDSCALE;
    end else begin
      WIPER0_TAP_O <= tap0; // [RQ17]
    end
  end

  // Latch 1 tap switches, midscale tap at reset
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      WIPER1_TAP_O <= {{(TAPS-1){1'h0}}, 1'h1} << `WL_MIDSCALE;
    end else begin
      WIPER1_TAP_O <= tap1; // [RQ17]
    end
  end

  // A terminals open while powered down
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      A_TERM_OPEN_O <= 1'h0;
    end else begin
      A_TERM_OPEN_O <= power_down_act; // [RQ14]
    end
  end

  // Wiper tied to the B terminal while powered down
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      WIPER_TO_B_O <= 1'h0;
    end else begin
      WIPER_TO_B_O <= power_down_act; // [RQ14]
    end
  end
endmodule

// ===== core/wiper_loader_consts.vh
`ifndef WIPER_LOADER_CONSTS_VH
`define WIPER_LOADER_CONSTS_VH

// Data word and code widths
`define WL_CODE_W 8
`define WL_TAPS 256
// Midscale preset code
`define WL_MIDSCALE 8'h80
// Position of the channel address bit in the dual-channel word
`define WL_ADDR_POS 8
// Word length of the dual-channel variant
`define WL_DUAL_LEN 9
// Chain output delay in shifts
`define WL_CHAIN_DEPTH 8

`endif

// ===== core/input_sync.v
`timescale 1ns/10ps
`include "wiper_loader_consts.vh"

// Two-stage synchroniser for one asynchronous level
module input_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire async_i,
  output reg sync_o
);
  reg meta_q;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ===== core/wiper_latch.v
`timescale 1ns/10ps
`include "wiper_loader_consts.vh"

// One wiper latch with its one-hot tap decoder
module wiper_latch #(
  parameter CODE_W = `WL_CODE_W,
  parameter TAPS = `WL_TAPS
) (
  input wire clk_i,
  input wire rst_i,
  input wire preset_i,
  input wire load_i,
  input wire [CODE_W-1:0] code_i,
  output reg [CODE_W-1:0] code_o,
  output reg [TAPS-1:0] tap_o
);
  wire [CODE_W-1:0] next_code;

  // Preset outranks any load; otherwise hold
  assign next_code = preset_i ? `WL_MIDSCALE : (load_i ? code_i : code_o);

  // Code and tap switch registered together, so exactly one tap is on
  always @(posedge clk_i) begin
    if (rst_i) begin
      code_o <= `WL_MIDSCALE;
      tap_o <= {{(TAPS-1){1'b0}}, 1'b1} << `WL_MIDSCALE;
    end else begin
      code_o <= next_code;
      tap_o <= {{(TAPS-1){1'b0}}, 1'b1} << next_code;
    end
  end
endmodule

// ===== dv/wl_master.sv
`timescale 1ns/10ps
// Serial master on the select, clock and data lines
module wl_master (
  output reg sclk_o,
  output reg cs_n_o,
  output reg sdi_o,
  input wire chain_i
);
  reg [15:0] got;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    got = 16'h0;
  end
  // Sends the low n bits of w MSB first, sampling the chain pin per shift
  task send(input [15:0] w, input integer n);
    integer i;
    begin
      cs_n_o = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        sdi_o = w[i];
        #32 sclk_o = 1'b1; // Slow 64 ns period suits a chain
        #32 got = {got[14:0], chain_i};
        sclk_o = 1'b0;
      end
      #32 cs_n_o = 1'b1; // One select pulse per word
      sdi_o = ~sdi_o; // Data line no longer meaningful
      #64;
    end
  endtask
endmodule

// ===== dv/serial_wiper_latch_loader_asserts.sv
`timescale 1ns/10ps
module serial_wiper_latch_loader_asserts #(parameter CODE_W = 8, parameter TAPS = 256) (
  input wire REF_CLK_I,
  input wire SRST_I,
  input wire CS_N_I,
  input wire PRESET_MID_N_I,
  input wire POWER_DOWN_N_I,
  input wire CHAIN_OUT_OE_N_O,
  input wire [CODE_W-1:0] WIPER0_CODE_O,
  input wire [CODE_W-1:0] WIPER1_CODE_O,
  input wire [TAPS-1:0] WIPER0_TAP_O,
  input wire [TAPS-1:0] WIPER1_TAP_O,
  input wire A_TERM_OPEN_O,
  input wire WIPER_TO_B_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  // Both codes at midscale, preset held, select idle
  sequence s_mid;
    WIPER0_CODE_O == 8'h80 && WIPER1_CODE_O == 8'h80;
  endsequence
  sequence s_pre_low;
    (!PRESET_MID_N_I)[*6];
  endsequence
  sequence s_quiet;
    (CS_N_I && PRESET_MID_N_I)[*8];
  endsequence
  a_reset_mid: assert property ($fell(SRST_I) |-> s_mid)
    else $error("codes not midscale after reset");
  a_tap_onehot: assert property ($onehot(WIPER0_TAP_O) && $onehot(WIPER1_TAP_O))
    else $error("taps not one-hot");
  a_tap_match: assert property (WIPER0_TAP_O[WIPER0_CODE_O] && WIPER1_TAP_O[WIPER1_CODE_O])
    else $error("tap does not match code");
  a_preset_mid: assert property (s_pre_low |-> s_mid)
    else $error("preset did not force midscale");
  a_pd_terms: assert property ((!POWER_DOWN_N_I)[*6] |-> A_TERM_OPEN_O && WIPER_TO_B_O && CHAIN_OUT_OE_N_O)
    else $error("power-down outputs wrong");
  a_run_terms: assert property (POWER_DOWN_N_I[*6] |-> !A_TERM_OPEN_O && !WIPER_TO_B_O)
    else $error("terminals switched while running");
  a_idle_stable: assert property (s_quiet |=> $stable(WIPER0_CODE_O) && $stable(WIPER1_CODE_O))
    else $error("code changed without a load");
  a_sel_float: assert property (CS_N_I[*6] |-> CHAIN_OUT_OE_N_O)
    else $error("chain pin driven while deselected");
endmodule

// ===== dv/serial_wiper_latch_loader_tb_top.sv
`timescale 1ns/10ps
module serial_wiper_latch_loader_tb_top;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg pre_n = 1'b1;
  reg pd_n = 1'b1;
  wire sclk, cs_n, serial_in, c_out, c_oe_n, a_open, w_b;
  wire [7:0] w0, w1, s_w0;
  wire [255:0] t0, t1;
  wire chain = c_oe_n ? 1'b1 : c_out; // Pull-up when released
  integer mismatches = 0;
  integer n_checks = 0;
  integer cyc = 0;
  always #2 clk = ~clk;
  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task t_dual;
    begin
      u_wl_master.send(16'h01c3, 9);
      chk(w1, 8'hc3);
      chk(w0, 8'h80);
      chk(s_w0, 8'hc3);
      u_wl_master.send(16'h005a, 9);
      chk(w0, 8'h5a);
      chk(w1, 8'hc3);
    end
  endtask
  task t_chain;
    begin
      u_wl_master.send(16'ha53c, 16);
      chk(u_wl_master.got[7:0], 8'ha5);
      chk(w1, 8'h3c);
    end
  endtask
  task t_preset;
    begin
      pre_n = 1'b0;
      u_wl_master.send(16'h0111, 9);
      chk(u_wl_master.got[7:0], 8'h00);
      chk(w1, 8'h80);
      pre_n = 1'b1;
      repeat (8) @(negedge clk);
      chk(w0, 8'h80);
    end
  endtask
  task t_pd;
    begin
      u_wl_master.send(16'h0177, 9);
      pd_n = 1'b0;
      repeat (8) @(negedge clk);
      chk({5'h0, a_open, w_b, c_oe_n}, 8'h07);
      u_wl_master.send(16'h0000, 9);
      chk(u_wl_master.got[7:0], 8'hff);
      pd_n = 1'b1;
      repeat (8) @(negedge clk);
      chk({5'h0, a_open, w_b, c_oe_n}, 8'h01);
      chk(w1, 8'h77);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk(w0, 8'h80);
    chk({7'h0, t1[128]}, 8'h01);
    t_dual;
    t_chain;
    t_preset;
    t_pd;
    give_verdict;
  end
  wl_master u_wl_master (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in), .chain_i(chain));
  serial_wiper_latch_loader u_serial_wiper_latch_loader (
    .REF_CLK_I(clk), .SRST_I(srst), .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_IN_I(serial_in),
    .PRESET_MID_N_I(pre_n), .POWER_DOWN_N_I(pd_n), .CHAIN_OUT_O(c_out),
    .CHAIN_OUT_OE_N_O(c_oe_n), .WIPER0_CODE_O(w0), .WIPER1_CODE_O(w1), .WIPER0_TAP_O(t0),
    .WIPER1_TAP_O(t1), .A_TERM_OPEN_O(a_open), .WIPER_TO_B_O(w_b));
  // Single-channel variant on the same link keeps the last eight bits
  serial_wiper_latch_loader #(.DUAL(0)) u_serial_wiper_latch_loader_single (
    .REF_CLK_I(clk), .SRST_I(srst), .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_IN_I(serial_in),
    .PRESET_MID_N_I(pre_n), .POWER_DOWN_N_I(pd_n), .CHAIN_OUT_O(), .CHAIN_OUT_OE_N_O(),
    .WIPER0_CODE_O(s_w0), .WIPER1_CODE_O(), .WIPER0_TAP_O(), .WIPER1_TAP_O(),
    .A_TERM_OPEN_O(), .WIPER_TO_B_O());
endmodule
bind serial_wiper_latch_loader serial_wiper_latch_loader_asserts #(.CODE_W(CODE_W), .TAPS(TAPS))
  u_chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .CS_N_I(CS_N_I),
  .PRESET_MID_N_I(PRESET_MID_N_I), .POWER_DOWN_N_I(POWER_DOWN_N_I),
  .CHAIN_OUT_OE_N_O(CHAIN_OUT_OE_N_O), .WIPER0_CODE_O(WIPER0_CODE_O),
  .WIPER1_CODE_O(WIPER1_CODE_O), .WIPER0_TAP_O(WIPER0_TAP_O), .WIPER1_TAP_O(WIPER1_TAP_O),
  .A_TERM_OPEN_O(A_TERM_OPEN_O), .WIPER_TO_B_O(WIPER_TO_B_O));
